// >>> hw/egs_reader.sv
// egs_reader: heater command sender and result frame reader for two sensors.
// assumes a frame-level CAN controller: rx frame strobe with id/data, tx
// strobe with ready; registers reached over a plain strobe port.
// Operation
// - bus bit rate is 250 kbit/s
// - controller acknowledges and transmits, never listen-only
// - receive timeout above 50 ms, 100 default
// - transmit wait below 10 ms, zero default
// - accept every frame, compare ids locally
// - channel starts running right after reset
// - restart bit resets the CAN channel
// - heater command id defaults 18FEDF00h
// - channel 1 results id defaults 18F00F52h
// - channel 2 results id defaults 18F00E51h
// - all three ids overridable as inputs
// - channel 1 request: full heat or preheat
// - channel 2 request: full heat or preheat
// - frame handed over only with update strobe
// - output identifier of last received frame
// - separate result bundle per channel
// - four two-bit status fields per channel
// - heater mode status field
// - three circuit fault status fields
// - presence indication per channel
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module egs_reader (
  input wire logic i_clk,
  input wire logic i_reset,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // frame-level CAN controller
  input wire logic i_rx_valid,
  input wire logic [28:0] i_rx_id,
  input wire logic i_rx_ext,
  input wire logic [63:0] i_rx_data,
  output logic o_tx_update,
  output logic [28:0] o_tx_id,
  output logic [3:0] o_tx_dlc,
  output logic [63:0] o_tx_data,
  input wire logic i_tx_ready,
  output logic o_can_reset,
  output logic o_listen_only,
  // identifiers
  input wire logic [28:0] i_heater_command_frame_id,
  input wire logic [28:0] i_channel1_result_frame_id,
  input wire logic [28:0] i_channel2_result_frame_id,
  output logic [28:0] o_last_seen_frame_id,
  // flat result bundles: {ocirc,ncirc,hcirc,hmode,o2v,noxv,temp,supply,o2,nox}
  output logic [56:0] o_channel1_result_bundle,
  output logic [56:0] o_channel2_result_bundle,
  output logic o_present1,
  output logic o_present2
);
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_STAT = 4'h1;
  localparam logic [3:0] A_LASTID = 4'h2;
  localparam logic [3:0] A_CH1A = 4'h3;
  localparam logic [3:0] A_CH2A = 4'h4;
  localparam logic [3:0] A_PERIOD = 4'h5;

  logic primary_heater_request_ff;
  logic secondary_heater_request_ff;
  logic channel_restart_ff;
  logic update_req_ff;
  logic [31:0] period_ff;
  logic [31:0] tick_ff;
  logic [31:0] rdata_ff;
  logic [28:0] last_id_ff;
  logic [28:0] tx_id_ff;
  logic [63:0] tx_data_ff;
  logic tx_upd_ff;
  logic can_reset_ff;
  logic [31:0] txw_ff;
  logic tx_drop_ff;
  egs_pkg::egs_tx_t tx_st_ff;
  logic hit1;
  logic hit2;
  logic [15:0] nox1, o2_1, nox2, o2_2;
  logic [1:0] sup1, tmp1, nv1, ov1, hm1, sup2, tmp2, nv2, ov2, hm2;
  logic [4:0] hc1, nc1, oc1, hc2, nc2, oc2;
  logic pres1, pres2;
  logic [56:0] b1_ff, b2_ff;
  logic p1_ff, p2_ff;
  logic [63:0] cmd_data;

  // every frame is accepted; selection is by local id compare
  assign hit1 = i_rx_valid && i_rx_ext && (i_rx_id == i_channel1_result_frame_id);
  assign hit2 = i_rx_valid && i_rx_ext && (i_rx_id == i_channel2_result_frame_id);

  // control register: bit0 ch1 request, bit1 ch2 request, bit2 restart pulse,
  // bit3 send-now pulse
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      primary_heater_request_ff <= 1'b0;
      secondary_heater_request_ff <= 1'b0;
      channel_restart_ff <= 1'b0;
      update_req_ff <= 1'b0;
      period_ff <= 32'h0000_0000;
    end else begin
      channel_restart_ff <= i_wr && (i_addr == A_CTRL) && i_wdata[2];
      update_req_ff <= i_wr && (i_addr == A_CTRL) && i_wdata[3];
      if (i_wr && i_addr == A_CTRL) begin
        primary_heater_request_ff <= i_wdata[0];
        secondary_heater_request_ff <= i_wdata[1];
      end
      if (i_wr && i_addr == A_PERIOD) begin
        period_ff <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      can_reset_ff <= 1'b0;
    end else begin
      can_reset_ff <= channel_restart_ff;
    end
  end

  // periodic command tick, period 0 sends only on demand
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tick_ff <= 32'h0000_0000;
    end else if (period_ff == 32'h0000_0000 || tick_ff >= period_ff - 32'h0000_0001) begin
      tick_ff <= 32'h0000_0000;
    end else begin
      tick_ff <= tick_ff + 32'h0000_0001;
    end
  end

  // byte 0: ch1 heater request, byte 1: ch2 heater request, rest fill
  always_comb begin
    cmd_data = egs_pkg::CMD_FILL;
    cmd_data[1:0] = primary_heater_request_ff ? egs_pkg::HEAT_FULL : egs_pkg::HEAT_PRE;
    cmd_data[9:8] = secondary_heater_request_ff ? egs_pkg::HEAT_FULL : egs_pkg::HEAT_PRE;
  end

  // transmit: present frame with strobe, wait at most the tx timeout, then drop
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_st_ff <= egs_pkg::TS_IDLE;
      tx_upd_ff <= 1'b0;
      tx_id_ff <= egs_pkg::HEATER_CMD_ID_DFLT;
      tx_data_ff <= 64'h0000_0000_0000_0000;
      txw_ff <= 32'h0000_0000;
      tx_drop_ff <= 1'b0;
    end else if (channel_restart_ff) begin
      tx_st_ff <= egs_pkg::TS_IDLE;
      tx_upd_ff <= 1'b0;
      txw_ff <= 32'h0000_0000;
    end else begin
      case (tx_st_ff)
        egs_pkg::TS_IDLE: begin
          if (update_req_ff || (period_ff != 32'h0000_0000 && tick_ff == 32'h0000_0000)) begin
            tx_id_ff <= i_heater_command_frame_id;
            tx_data_ff <= cmd_data;
            tx_upd_ff <= 1'b1;
            txw_ff <= 32'h0000_0000;
            tx_st_ff <= egs_pkg::TS_SEND;
          end
        end
        egs_pkg::TS_SEND: begin
          if (i_tx_ready) begin
            tx_upd_ff <= 1'b0;
            tx_st_ff <= egs_pkg::TS_WAIT;
          end else if (txw_ff >= egs_pkg::TX_TIMEOUT_CYCLES - 1) begin
            tx_upd_ff <= 1'b0;
            tx_drop_ff <= 1'b1;
            tx_st_ff <= egs_pkg::TS_WAIT;
          end else begin
            txw_ff <= txw_ff + 32'h0000_0001;
          end
        end
        egs_pkg::TS_WAIT: begin
          tx_st_ff <= egs_pkg::TS_IDLE;
        end
        default: begin
          tx_st_ff <= egs_pkg::TS_IDLE;
          tx_upd_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      last_id_ff <= 29'h0000_0000;
    end else if (i_rx_valid) begin
      last_id_ff <= i_rx_id;
    end
  end

  egs_result u_ch1 (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_restart(channel_restart_ff),
    .i_hit(hit1),
    .i_data(i_rx_data),
    .o_nox_raw(nox1),
    .o_o2_raw(o2_1),
    .o_supply(sup1),
    .o_temp(tmp1),
    .o_nox_valid(nv1),
    .o_o2_valid(ov1),
    .o_hmode(hm1),
    .o_hcirc(hc1),
    .o_ncirc(nc1),
    .o_ocirc(oc1),
    .o_present(pres1)
  );

  egs_result u_ch2 (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_restart(channel_restart_ff),
    .i_hit(hit2),
    .i_data(i_rx_data),
    .o_nox_raw(nox2),
    .o_o2_raw(o2_2),
    .o_supply(sup2),
    .o_temp(tmp2),
    .o_nox_valid(nv2),
    .o_o2_valid(ov2),
    .o_hmode(hm2),
    .o_hcirc(hc2),
    .o_ncirc(nc2),
    .o_ocirc(oc2),
    .o_present(pres2)
  );

  // output copies so the result bundle and presence outputs come from a flop
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      b1_ff <= 57'h0;
      b2_ff <= 57'h0;
      p1_ff <= 1'b0;
      p2_ff <= 1'b0;
    end else begin
      b1_ff <= {oc1, nc1, hc1, hm1, ov1, nv1, tmp1, sup1, o2_1, nox1};
      b2_ff <= {oc2, nc2, hc2, hm2, ov2, nv2, tmp2, sup2, o2_2, nox2};
      p1_ff <= pres1;
      p2_ff <= pres2;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        A_CTRL: rdata_ff <= {30'h0, secondary_heater_request_ff, primary_heater_request_ff};
        A_STAT: rdata_ff <= {27'h0, tx_drop_ff, tx_upd_ff, can_reset_ff, p2_ff, p1_ff};
        A_LASTID: rdata_ff <= {3'h0, last_id_ff};
        A_CH1A: rdata_ff <= {o2_1, nox1};
        A_CH2A: rdata_ff <= {o2_2, nox2};
        A_PERIOD: rdata_ff <= period_ff;
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_tx_update = tx_upd_ff;
  assign o_tx_id = tx_id_ff;
  assign o_tx_dlc = egs_pkg::CMD_DLC;
  assign o_tx_data = tx_data_ff;
  assign o_can_reset = can_reset_ff;
  // controller bit timing is egs_pkg::CAN_BIT_CYCLES clocks per bit
  assign o_listen_only = 1'b0;
  assign o_last_seen_frame_id = last_id_ff;
  assign o_channel1_result_bundle = b1_ff;
  assign o_channel2_result_bundle = b2_ff;
  assign o_present1 = p1_ff;
  assign o_present2 = p2_ff;

  AST_TX_ONLY_IN_SEND: assert property (@(posedge i_clk) disable iff (i_reset)
    o_tx_update |-> tx_st_ff == egs_pkg::TS_SEND)
    else $error("update strobe outside send state");
  AST_TX_ID_CMD: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_tx_update) |-> o_tx_id == $past(i_heater_command_frame_id))
    else $error("command id mismatch");
  AST_TX_HEAT1: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_tx_update) |-> o_tx_data[1:0] ==
      ($past(primary_heater_request_ff) ? egs_pkg::HEAT_FULL : egs_pkg::HEAT_PRE))
    else $error("channel 1 heater request wrong");
  AST_TX_HEAT2: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_tx_update) |-> o_tx_data[9:8] ==
      ($past(secondary_heater_request_ff) ? egs_pkg::HEAT_FULL : egs_pkg::HEAT_PRE))
    else $error("channel 2 heater request wrong");
  AST_TX_FILL: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_tx_update) |-> o_tx_data[63:10] == egs_pkg::CMD_FILL[63:10] &&
      o_tx_data[7:2] == egs_pkg::CMD_FILL[7:2])
    else $error("command fill bits wrong");
  AST_TX_TIMEOUT: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_tx_update) |-> ##[1:2] !o_tx_update)
    else $error("transmit wait exceeded");
  AST_TX_DROP: assert property (@(posedge i_clk) disable iff (i_reset)
    o_tx_update && !i_tx_ready && !channel_restart_ff |=> tx_drop_ff)
    else $error("unaccepted frame not flagged as dropped");
  AST_LAST_ID: assert property (@(posedge i_clk) disable iff (i_reset)
    i_rx_valid |=> o_last_seen_frame_id == $past(i_rx_id))
    else $error("last id not captured");
  AST_LAST_ID_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_rx_valid |=> $stable(o_last_seen_frame_id))
    else $error("last id changed without a frame");
  AST_PRESENT1: assert property (@(posedge i_clk) disable iff (i_reset)
    hit1 |-> ##2 o_present1)
    else $error("channel 1 presence missing");
  AST_PRESENT2: assert property (@(posedge i_clk) disable iff (i_reset)
    hit2 |-> ##2 o_present2)
    else $error("channel 2 presence missing");
  AST_RESTART: assert property (@(posedge i_clk) disable iff (i_reset)
    i_wr && i_addr == A_CTRL && i_wdata[2] |-> ##2 o_can_reset ##1 !o_can_reset)
    else $error("restart pulse wrong");
  AST_RESTART_CLEAR1: assert property (@(posedge i_clk) disable iff (i_reset)
    channel_restart_ff && !hit1 |-> ##2 !o_present1)
    else $error("channel 1 presence kept over restart");
  AST_RESTART_CLEAR2: assert property (@(posedge i_clk) disable iff (i_reset)
    channel_restart_ff && !hit2 |-> ##2 !o_present2)
    else $error("channel 2 presence kept over restart");
  AST_LISTEN: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_listen_only)
    else $error("listen only asserted");
  AST_CH1_BUNDLE: assert property (@(posedge i_clk) disable iff (i_reset)
    hit1 && !hit2 |-> ##2 o_channel1_result_bundle[15:0] == $past(i_rx_data[15:0], 2))
    else $error("channel 1 bundle not updated");
  AST_CH2_BUNDLE: assert property (@(posedge i_clk) disable iff (i_reset)
    hit2 && !hit1 |-> ##2 o_channel2_result_bundle[15:0] == $past(i_rx_data[15:0], 2))
    else $error("channel 2 bundle not updated");
  CV_TX: cover property (@(posedge i_clk) o_tx_update ##1 !o_tx_update);
  CV_CH1: cover property (@(posedge i_clk) hit1 ##2 o_present1);
  CV_CH2: cover property (@(posedge i_clk) hit2 ##2 o_present2);
  CV_RESTART: cover property (@(posedge i_clk) o_can_reset);
endmodule
`default_nettype wire

// >>> pkg/egs_pkg.sv
// egs_pkg: constants and types shared by the exhaust-gas sensor frame reader.
// assumes a 40 MHz system clock and a frame-level CAN controller outside.
package egs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CAN_BIT_RATE = 250_000;
  localparam int unsigned CAN_BIT_CYCLES = CLK_HZ / CAN_BIT_RATE;
  localparam int unsigned RX_TIMEOUT_MS = 100;
  localparam int unsigned RX_TIMEOUT_MIN_MS = 50;
  localparam int unsigned TX_TIMEOUT_MS = 0;
  localparam int unsigned RX_TIMEOUT_CYCLES = RX_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned TX_TIMEOUT_CYCLES = (TX_TIMEOUT_MS * (CLK_HZ / 1000) > 0) ?
    TX_TIMEOUT_MS * (CLK_HZ / 1000) : 1;
  localparam int unsigned PREHEAT_LOW_C = 80;
  localparam int unsigned PREHEAT_HIGH_C = 120;
  localparam logic [28:0] HEATER_CMD_ID_DFLT = 29'h18FE_DF00;
  localparam logic [28:0] CH1_RESULT_ID_DFLT = 29'h18F0_0F52;
  localparam logic [28:0] CH2_RESULT_ID_DFLT = 29'h18F0_0E51;
  // payload field positions (bytes little-endian within the 64-bit data word)
  localparam int unsigned NOX_LSB = 0;
  localparam int unsigned O2_LSB = 16;
  localparam int unsigned SUPPLY_LSB = 32;
  localparam int unsigned TEMP_LSB = 34;
  localparam int unsigned NOXVAL_LSB = 36;
  localparam int unsigned O2VAL_LSB = 38;
  localparam int unsigned HMODE_LSB = 40;
  localparam int unsigned HCIRC_LSB = 48;
  localparam int unsigned NCIRC_LSB = 53;
  localparam int unsigned OCIRC_LSB = 58;
  localparam logic [1:0] HEAT_FULL = 2'h1;
  localparam logic [1:0] HEAT_PRE = 2'h0;
  localparam logic [63:0] CMD_FILL = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [3:0] CMD_DLC = 4'h8;
  typedef enum logic [1:0] {ST_ON = 2'h0, ST_OK = 2'h1, ST_ERR = 2'h2, ST_NA = 2'h3} egs_stat_t;
  typedef enum logic [1:0] {HM_AUTO = 2'h0, HM_SLOPE34 = 2'h1, HM_SLOPE12 = 2'h2,
    HM_OFF = 2'h3} egs_hmode_t;
  typedef enum logic [4:0] {CF_OPEN = 5'h05, CF_SHORT = 5'h03, CF_NONE = 5'h1F} egs_circ_t;
  typedef enum logic [1:0] {TS_IDLE = 2'h0, TS_SEND = 2'h1, TS_WAIT = 2'h3} egs_tx_t;
endpackage

// >>> hw/egs_result.sv
// egs_result: one sensor channel's result bundle and presence timer.
// assumes frame strobes are single-cycle and already filtered by identifier.
`timescale 1ns/100ps
`default_nettype none
module egs_result (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_restart,
  input wire logic i_hit,
  input wire logic [63:0] i_data,
  output logic [15:0] o_nox_raw,
  output logic [15:0] o_o2_raw,
  output logic [1:0] o_supply,
  output logic [1:0] o_temp,
  output logic [1:0] o_nox_valid,
  output logic [1:0] o_o2_valid,
  output logic [1:0] o_hmode,
  output logic [4:0] o_hcirc,
  output logic [4:0] o_ncirc,
  output logic [4:0] o_ocirc,
  output logic o_present
);
  logic [63:0] data_ff;
  logic [31:0] age_ff;
  logic present_ff;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      data_ff <= 64'hFFFF_FFFF_FFFF_FFFF;
    end else if (i_hit) begin
      data_ff <= i_data;
    end
  end

  // presence holds while frames keep arriving within the receive timeout
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      age_ff <= 32'h0000_0000;
      present_ff <= 1'b0;
    end else if (i_hit) begin
      // a frame in the restart cycle wins, so a live sensor is not lost
      age_ff <= 32'h0000_0000;
      present_ff <= 1'b1;
    end else if (i_restart) begin
      age_ff <= 32'h0000_0000;
      present_ff <= 1'b0;
    end else if (age_ff >= egs_pkg::RX_TIMEOUT_CYCLES - 1) begin
      present_ff <= 1'b0;
    end else begin
      age_ff <= age_ff + 32'h0000_0001;
    end
  end

  assign o_nox_raw = data_ff[egs_pkg::NOX_LSB +: 16];
  assign o_o2_raw = data_ff[egs_pkg::O2_LSB +: 16];
  assign o_supply = data_ff[egs_pkg::SUPPLY_LSB +: 2];
  assign o_temp = data_ff[egs_pkg::TEMP_LSB +: 2];
  assign o_nox_valid = data_ff[egs_pkg::NOXVAL_LSB +: 2];
  assign o_o2_valid = data_ff[egs_pkg::O2VAL_LSB +: 2];
  assign o_hmode = data_ff[egs_pkg::HMODE_LSB +: 2];
  assign o_hcirc = data_ff[egs_pkg::HCIRC_LSB +: 5];
  assign o_ncirc = data_ff[egs_pkg::NCIRC_LSB +: 5];
  assign o_ocirc = data_ff[egs_pkg::OCIRC_LSB +: 5];
  assign o_present = present_ff;

  AST_PRESENT_ON_HIT: assert property (@(posedge i_clk) disable iff (i_reset)
    i_hit |=> o_present)
    else $error("presence not set after result frame");
endmodule
`default_nettype wire

// >>> sim/egs_sensor_model.sv
// egs_sensor_model: frame-level CAN controller with one or two sensor modules behind it.
// assumes the reader's frame port; the bench calls send() to put a result frame on the bus.
`timescale 1ns/100ps
`default_nettype none
module egs_sensor_model (
  input wire logic i_clk,
  input wire logic i_tx_update,
  input wire logic [28:0] i_tx_id,
  input wire logic [63:0] i_tx_data,
  input wire logic i_can_reset,
  input wire logic i_listen_only,
  input wire logic i_slow,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [28:0] o_rx_id,
  output logic o_rx_ext,
  output logic [63:0] o_rx_data
);
  int n_off = 0;
  int n_tx = 0;
  int n_rst = 0;
  int len = 0;
  logic upd_q = 1'b0;
  logic [28:0] last_id = 29'h0000_0000;
  logic [63:0] last_data = 64'h0000_0000_0000_0000;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_id = 29'h0000_0000;
    o_rx_ext = 1'b0;
    o_rx_data = 64'h0000_0000_0000_0000;
  end
  // bit timing at 250 kbit/s is abstracted to whole frames
  // a slow node never accepts; a listen-only controller would never accept either
  assign o_tx_ready = i_tx_update & ~i_slow & ~i_listen_only;
  always @(posedge i_clk) begin
    upd_q <= i_tx_update;
    if (i_tx_update && !upd_q) begin
      n_off <= n_off + 1;
      len <= 1;
    end else if (i_tx_update) begin
      len <= len + 1;
    end
    if (o_tx_ready) begin
      n_tx <= n_tx + 1;
      last_id <= i_tx_id;
      last_data <= i_tx_data;
    end
    if (i_can_reset) begin
      n_rst <= n_rst + 1;
    end
  end
  // result frame from a sensor module; lines show the inverse once released
  task automatic send(input logic [28:0] id, input logic ext, input logic [63:0] data);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_id <= id;
    o_rx_ext <= ext;
    o_rx_data <= data;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_id <= ~id;
    o_rx_ext <= ~ext;
    o_rx_data <= ~data;
  endtask
endmodule
`default_nettype wire

// >>> sim/test_egs_reader.sv
// test_egs_reader: self-checking bench for the sensor frame reader.
// assumes egs_sensor_model on the frame port and a 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module test_egs_reader;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic slow = 1'b0;
  logic [28:0] hid = egs_pkg::HEATER_CMD_ID_DFLT;
  logic [28:0] c1id = egs_pkg::CH1_RESULT_ID_DFLT;
  logic [28:0] c2id = egs_pkg::CH2_RESULT_ID_DFLT;
  logic [31:0] o_rdata, rd;
  logic rx_valid, rx_ext, tx_ready, tx_update, can_reset, listen_only, p1, p2;
  logic [28:0] rx_id, tx_id, last_id, id;
  logic [63:0] rx_data, tx_data, dat;
  logic [3:0] tx_dlc;
  logic [56:0] b1, b2;
  logic [56:0] eb[2];
  logic [4:0] cc[3];
  logic [1:0] s;
  logic [15:0] nox, o2;
  int err_count = 0;
  int n_compared = 0;
  int noff = 0;
  int n0, ch;
  always #12.5 i_clk = ~i_clk;
  egs_reader uut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(rx_valid), .i_rx_id(rx_id),
    .i_rx_ext(rx_ext), .i_rx_data(rx_data), .o_tx_update(tx_update), .o_tx_id(tx_id),
    .o_tx_dlc(tx_dlc), .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_can_reset(can_reset),
    .o_listen_only(listen_only), .i_heater_command_frame_id(hid),
    .i_channel1_result_frame_id(c1id), .i_channel2_result_frame_id(c2id),
    .o_last_seen_frame_id(last_id), .o_channel1_result_bundle(b1),
    .o_channel2_result_bundle(b2), .o_present1(p1), .o_present2(p2));
  egs_sensor_model sm (.i_clk(i_clk), .i_tx_update(tx_update), .i_tx_id(tx_id),
    .i_tx_data(tx_data), .i_can_reset(can_reset), .i_listen_only(listen_only),
    .i_slow(slow), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_id(rx_id),
    .o_rx_ext(rx_ext), .o_rx_data(rx_data));
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk_w(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  // one more command frame offered, then let the sender settle
  task automatic wait_off();
    int i;
    noff++;
    for (i = 0; i < 40 && sm.n_off != noff; i++) @(negedge i_clk);
    if (sm.n_off != noff) begin
      err_count++;
      $display("CHECK FAILED at %0t: no command frame offered", $time);
      print_verdict();
    end else begin
      repeat (4) @(negedge i_clk);
    end
  endtask
  task automatic settle_rx();
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  initial begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    print_verdict();
  end
  initial begin
    cc = '{egs_pkg::CF_OPEN, egs_pkg::CF_SHORT, egs_pkg::CF_NONE};
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (5) @(negedge i_clk);
    chk_w(64'(tx_id), 64'(egs_pkg::HEATER_CMD_ID_DFLT));
    chk_w(64'(tx_dlc), 64'(egs_pkg::CMD_DLC));
    chk_b(listen_only, 1'b0);
    chk_w(64'(b1), 64'h01FF_FFFF_FFFF_FFFF);
    chk_b(p1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      reg_wr(4'h0, 32'h0000_0008 | 32'(k));
      wait_off();
      chk_w(sm.last_data, {48'hFFFF_FFFF_FFFF, 6'h3F, k[1] ? egs_pkg::HEAT_FULL : egs_pkg::HEAT_PRE,
        6'h3F, k[0] ? egs_pkg::HEAT_FULL : egs_pkg::HEAT_PRE});
      chk_w(64'(sm.last_id), 64'(egs_pkg::HEATER_CMD_ID_DFLT));
      reg_rd(4'h0, rd);
      chk_w(64'(rd[1:0]), 64'(k));
    end
    slow <= 1'b1;
    n0 = sm.n_tx;
    reg_wr(4'h0, 32'h0000_0008);
    wait_off();
    chk_w(64'(sm.len), 64'h1);
    chk_w(64'(sm.n_tx), 64'(n0));
    reg_rd(4'h1, rd);
    chk_b(rd[4], 1'b1);
    slow <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      s = 2'(k);
      nox = 16'h8000 | 16'(k);
      o2 = 16'hFFF0 | 16'(k);
      ch = k % 2;
      id = (ch == 1) ? c2id : c1id;
      dat = {1'b1, cc[(k + 2) % 3], cc[(k + 1) % 3], cc[k % 3], 6'h3F, s, s + 2'h3, s + 2'h2,
        s + 2'h1, s, o2, nox};
      eb[ch] = 57'({cc[(k + 2) % 3], cc[(k + 1) % 3], cc[k % 3], s, s + 2'h3, s + 2'h2,
        s + 2'h1, s, o2, nox});
      sm.send(id, 1'b1, dat);
      settle_rx();
      chk_w(64'((ch == 1) ? b2 : b1), 64'(eb[ch]));
      chk_w(64'(last_id), 64'(id));
      reg_rd((ch == 1) ? 4'h4 : 4'h3, rd);
      chk_w(64'(rd), 64'({o2, nox}));
    end
    chk_b(p1, 1'b1);
    chk_b(p2, 1'b1);
    sm.send(c1id, 1'b0, 64'h0000_0000_0000_0000);
    settle_rx();
    chk_w(64'(b1), 64'(eb[0]));
    chk_w(64'(last_id), 64'(c1id));
    sm.send(29'h0000_0123, 1'b1, 64'h0000_0000_0000_0000);
    settle_rx();
    chk_w(64'(b1), 64'(eb[0]));
    chk_w(64'(b2), 64'(eb[1]));
    reg_rd(4'h2, rd);
    chk_w(64'(rd), 64'h0000_0123);
    reg_rd(4'hF, rd);
    chk_w(64'(rd), 64'h0);
    @(posedge i_clk);
    c1id <= 29'h1ABC_0001;
    hid <= 29'h0CF0_0001;
    sm.send(29'h1ABC_0001, 1'b1, 64'hFFFF_FFFF_FFFF_1234);
    settle_rx();
    chk_w(64'(b1[15:0]), 64'h1234);
    reg_wr(4'h0, 32'h0000_0008);
    wait_off();
    chk_w(64'(sm.last_id), 64'(29'h0CF0_0001));
    @(posedge i_clk);
    c1id <= egs_pkg::CH1_RESULT_ID_DFLT;
    hid <= egs_pkg::HEATER_CMD_ID_DFLT;
    n0 = sm.n_off;
    reg_wr(4'h5, 32'h0000_0032);
    reg_rd(4'h5, rd);
    chk_w(64'(rd), 64'h32);
    repeat (200) @(negedge i_clk);
    chk_b(sm.n_off - n0 >= 3 && sm.n_off - n0 <= 5, 1'b1);
    reg_wr(4'h5, 32'h0000_0000);
    repeat (10) @(negedge i_clk);
    noff = sm.n_off;
    n0 = sm.n_rst;
    reg_wr(4'h0, 32'h0000_0004);
    repeat (6) @(negedge i_clk);
    chk_w(64'(sm.n_rst - n0), 64'h1);
    chk_b(p1, 1'b0);
    chk_b(p2, 1'b0);
    chk_w(64'(b2), 64'(eb[1]));
    print_verdict();
  end
endmodule
`default_nettype wire
